// >>> rtl/utgsc_pkg.sv
// constants and types shared by the transmit gap and suspend control block
// assumes a 32-bit ahb-lite register bus and a baud tick in the peripheral clock domain
package utgsc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [31:0] FFCT_IDX      = 32'h0000705c;
  localparam logic [31:0] PRI_IDX       = 32'h0000705f;
  localparam logic [31:0] IRQ_STAT_IDX  = 32'h00007060;
  localparam logic [31:0] IRQ_MASK_IDX  = 32'h00007061;
  localparam logic [31:0] FFCT_ADDR     = {FFCT_IDX[29:0], 2'b00};
  localparam logic [31:0] PRI_ADDR      = {PRI_IDX[29:0], 2'b00};
  localparam logic [31:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX[29:0], 2'b00};
  localparam logic [31:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX[29:0], 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ABD_BIT     = 15;
  localparam int AUTOBAUD_DONE_CLEAR_BIT = 14;
  localparam int ALIGN_BIT   = 13;
  localparam int GAP_MSB     = 7;
  localparam int GAP_LSB     = 0;
  localparam int SUSP_MSB    = 4;
  localparam int SUSP_LSB    = 3;
  localparam int IRQ_ABD     = 0;
  localparam int IRQ_HALT    = 1;
  localparam int IRQ_W       = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]       GAP_RST   = 8'h00;
  localparam logic             ALIGN_RST = 1'b0;
  localparam logic             ABD_RST   = 1'b0;
  localparam logic [1:0]       SUSP_RST  = 2'h0;
  localparam logic [IRQ_W-1:0] STAT_RST  = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RST  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // gap counter: 9 bits so the full range is representable
  localparam int           GAP_CNT_W     = 9;
  localparam logic [8:0]   TWO_STOP_TRIM = 9'h001;
  localparam logic [1:0]   SUSP_IMMEDIATE = 2'h0;
  localparam logic [1:0]   SUSP_COMPLETE  = 2'h2;

  typedef enum logic [1:0] {
    TX_READY,
    TX_LOAD,
    TX_SHIFT,
    TX_GAP
  } utgsc_tx_state_t;

endpackage

// >>> rtl/utgsc_top.sv
// transmit frame gap, auto-baud enable/flag and debug suspend control of a serial port
// assumes ahb-lite single word transfers, baud_tick one cycle wide per baud clock,
// and a shifter that raises tx_shift_busy after tx_load and drops it after the last stop bit
//
// Operation
// - auto-baud alignment is enabled only while control bit 13 of the fifo control register is one.
// - an 8-bit field in bits 7-0 sets a delay in baud clocks between transmit fifo to shifter moves.
// - the delay spans 0 up to 255 baud clock cycles.
// - in fifo mode the shifter is loaded only after it has finished its last bit, so the gap shows on the line.
// - with one stop bit the inserted gap equals the programmed value in baud clocks.
// - with two stop bits the inserted gap equals the programmed value minus one baud clock.
// - suspend field value 00 halts serial activity immediately on an emulation suspend.
// - suspend field value 10 finishes the receive or transmit in progress, then halts.
// - a one in the low suspend bit means free run, ignoring suspend.
// - reserved bits 7-5 and 2-0 of the suspend priority register read zero and ignore writes.
// - the auto-baud done flag at bit 15 sets when an A or a has been detected and reads zero before.
// - writing one to bit 14 clears the auto-baud done flag, writing zero does nothing, bit 14 reads zero.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module utgsc_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        tx_fifo_valid,
  input  wire logic [7:0]  tx_fifo_data,
  output logic             tx_fifo_pop,
  input  wire logic        fifo_mode,
  input  wire logic        two_stop_bits,
  input  wire logic        baud_tick,
  input  wire logic        tx_shift_busy,
  output logic             tx_load,
  output logic [7:0]       tx_load_data,
  input  wire logic        rx_busy,
  input  wire logic        emu_suspend,
  input  wire logic        autobaud_detected,
  output logic             autobaud_align_enable,
  output logic             serial_halt,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus and register state
  logic                        wr_pend_q, wr_pend_d;
  logic [31:0]                 wr_addr_q, wr_addr_d;
  logic [31:0]                 hrdata_d;
  logic [7:0]                  gap_q, gap_d;
  logic                        align_q, align_d;
  logic                        abd_q, abd_d;
  logic [1:0]                  susp_q, susp_d;
  logic [utgsc_pkg::IRQ_W-1:0] stat_q, stat_d;
  logic [utgsc_pkg::IRQ_W-1:0] mask_q, mask_d;
  logic [utgsc_pkg::IRQ_W-1:0] event_set;
  logic                        irq_d;
  logic                        acc;
  logic                        wr_ffct, wr_pri, wr_stat, wr_mask;

  // transmit and suspend state
  utgsc_pkg::utgsc_tx_state_t              st_q, st_d;
  logic [utgsc_pkg::GAP_CNT_W-1:0]         cnt_q, cnt_d;
  logic [utgsc_pkg::GAP_CNT_W-1:0]         gap_len;
  logic                                    load_d, pop_d;
  logic [7:0]                              load_data_d;
  logic                                    halt_q, halt_d;
  logic                                    free_run;

  ////////////////////////////////////////////////////////////////////////////////
  // register next values; read data is taken from the _d values so a read
  // straight after a write returns the new contents with no wait state
  always_comb begin
    acc       = hsel & htrans[1] & hready;
    wr_pend_d = acc & hwrite;
    wr_addr_d = haddr;
    wr_ffct   = wr_pend_q & (wr_addr_q == utgsc_pkg::FFCT_ADDR);
    wr_pri    = wr_pend_q & (wr_addr_q == utgsc_pkg::PRI_ADDR);
    wr_stat   = wr_pend_q & (wr_addr_q == utgsc_pkg::IRQ_STAT_ADDR);
    wr_mask   = wr_pend_q & (wr_addr_q == utgsc_pkg::IRQ_MASK_ADDR);

    gap_d   = wr_ffct ? hwdata[utgsc_pkg::GAP_MSB:utgsc_pkg::GAP_LSB] : gap_q;
    align_d = wr_ffct ? hwdata[utgsc_pkg::ALIGN_BIT] : align_q;
    // reserved bits never stored
    susp_d  = wr_pri ? hwdata[utgsc_pkg::SUSP_MSB:utgsc_pkg::SUSP_LSB] : susp_q;
    mask_d  = wr_mask ? hwdata[utgsc_pkg::IRQ_W-1:0] : mask_q;

    // detection only counts while alignment is enabled; set wins over clear
    event_set                     = '0;
    event_set[utgsc_pkg::IRQ_ABD]  = autobaud_detected & align_q;
    event_set[utgsc_pkg::IRQ_HALT] = halt_d & ~halt_q;
    abd_d = (abd_q & ~(wr_ffct & hwdata[utgsc_pkg::AUTOBAUD_DONE_CLEAR_BIT]))
          | event_set[utgsc_pkg::IRQ_ABD];
    stat_d = (stat_q & ~(wr_stat ? hwdata[utgsc_pkg::IRQ_W-1:0] : '0)) | event_set;
    irq_d  = |(stat_d & mask_d);

    hrdata_d = 32'h00000000;
    if (acc & ~hwrite) begin
      case (haddr)
        utgsc_pkg::FFCT_ADDR: begin
          // clear bit always reads zero
          hrdata_d[utgsc_pkg::ABD_BIT]                         = abd_d;
          hrdata_d[utgsc_pkg::ALIGN_BIT]                       = align_d;
          hrdata_d[utgsc_pkg::GAP_MSB:utgsc_pkg::GAP_LSB]      = gap_d;
        end
        utgsc_pkg::PRI_ADDR:      hrdata_d[utgsc_pkg::SUSP_MSB:utgsc_pkg::SUSP_LSB] = susp_d;
        utgsc_pkg::IRQ_STAT_ADDR: hrdata_d[utgsc_pkg::IRQ_W-1:0] = stat_d;
        utgsc_pkg::IRQ_MASK_ADDR: hrdata_d[utgsc_pkg::IRQ_W-1:0] = mask_d;
        default:                  hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h00000000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      gap_q     <= utgsc_pkg::GAP_RST;
      align_q   <= utgsc_pkg::ALIGN_RST;
      abd_q     <= utgsc_pkg::ABD_RST;
      susp_q    <= utgsc_pkg::SUSP_RST;
      stat_q    <= utgsc_pkg::STAT_RST;
      mask_q    <= utgsc_pkg::MASK_RST;
      irq       <= 1'b0;
      autobaud_align_enable <= utgsc_pkg::ALIGN_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      gap_q     <= gap_d;
      align_q   <= align_d;
      abd_q     <= abd_d;
      susp_q    <= susp_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      irq       <= irq_d;
      autobaud_align_enable <= align_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // suspend: the halt output freezes shifter and receiver, and stops new loads
  always_comb begin
    free_run = susp_q[0];
    halt_d   = 1'b0;
    if (!free_run && emu_suspend) begin
      if (susp_q == utgsc_pkg::SUSP_IMMEDIATE)
        halt_d = 1'b1;
      else
        // wait for both directions to go quiet before stopping
        halt_d = halt_q | ~(tx_shift_busy | rx_busy | (st_q == utgsc_pkg::TX_LOAD));
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      halt_q      <= 1'b0;
      serial_halt <= 1'b0;
    end else begin
      halt_q      <= halt_d;
      serial_halt <= halt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit pacing; the holding stage never buffers ahead, it is loaded only
  // once the shifter is idle, otherwise the gap would be swallowed
  always_comb begin
    // two stop bits already give one extra idle baud clock
    if (two_stop_bits)
      gap_len = (gap_q == 8'h00) ? '0 : {1'b0, gap_q} - utgsc_pkg::TWO_STOP_TRIM;
    else
      gap_len = {1'b0, gap_q};
    st_d        = st_q;
    cnt_d       = cnt_q;
    load_d      = 1'b0;
    pop_d       = 1'b0;
    load_data_d = tx_load_data;
    case (st_q)
      utgsc_pkg::TX_READY: begin
        // a complete-mode suspend must not start a new frame
        if (tx_fifo_valid && !tx_shift_busy && !halt_q && !(emu_suspend && !free_run)) begin
          load_d      = 1'b1;
          pop_d       = 1'b1;
          load_data_d = tx_fifo_data;
          st_d        = utgsc_pkg::TX_LOAD;
        end
      end
      utgsc_pkg::TX_LOAD: begin
        if (tx_shift_busy)
          st_d = utgsc_pkg::TX_SHIFT;
      end
      utgsc_pkg::TX_SHIFT: begin
        if (!tx_shift_busy) begin
          cnt_d = gap_len;
          if (fifo_mode && gap_len != '0)
            st_d = utgsc_pkg::TX_GAP;
          else
            st_d = utgsc_pkg::TX_READY;
        end
      end
      utgsc_pkg::TX_GAP: begin
        // counter frozen while halted
        if (baud_tick && !halt_q) begin
          cnt_d = cnt_q - 9'h001;
          if (cnt_q == 9'h001)
            st_d = utgsc_pkg::TX_READY;
        end
      end
      default: st_d = utgsc_pkg::TX_READY;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q         <= utgsc_pkg::TX_READY;
      cnt_q        <= '0;
      tx_load      <= 1'b0;
      tx_fifo_pop  <= 1'b0;
      tx_load_data <= 8'h00;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      tx_load      <= load_d;
      tx_fifo_pop  <= pop_d;
      tx_load_data <= load_data_d;
    end
  end

endmodule // utgsc_top

// >>> tb/utgsc_monitor.sv
// concurrent checks on the gap and suspend block, port view only
// assumes binding to utgsc_top; suspend mode is tracked by snooping bus writes
`timescale 1ns/1ns
module utgsc_monitor (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        tx_load,
  input wire logic        tx_fifo_pop,
  input wire logic        tx_shift_busy,
  input wire logic        emu_suspend,
  input wire logic        serial_halt
);
  logic       pend_q;
  logic [1:0] mode_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // shadow of the suspend field, updated on the same edge as the register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      pend_q <= hsel && htrans[1] && hready && hwrite && haddr == utgsc_pkg::PRI_ADDR;
      if (pend_q) mode_q <= hwdata[4:3];
    end
  end
  sequence s_load;
    tx_load && tx_fifo_pop;
  endsequence
  a_load_pair: assert property (tx_load == tx_fifo_pop) else $error("load without pop");
  a_load_idle: assert property (tx_load |-> !$past(tx_shift_busy)) else $error("load while busy");
  a_load_once: assert property (s_load |=> !tx_load) else $error("load not a pulse");
  a_halt_now: assert property (emu_suspend && mode_q == 2'h0 |=> serial_halt) else $error("no halt");
  a_free_run: assert property (mode_q[0] && $past(mode_q[0]) |-> !serial_halt) else $error("halt in free");
  a_halt_drop: assert property (!emu_suspend |=> !serial_halt) else $error("halt stuck");
  a_finish_first: assert property (mode_q == 2'h2 && emu_suspend && tx_shift_busy && !serial_halt
    |=> !serial_halt) else $error("early halt");
  a_halt_noload: assert property (serial_halt && $past(serial_halt) |-> !tx_load) else $error("load halted");
endmodule // utgsc_monitor

bind utgsc_top utgsc_monitor u_mon (.clock, .nrst, .hsel, .haddr, .htrans, .hready, .hwrite, .hwdata,
  .tx_load, .tx_fifo_pop, .tx_shift_busy, .emu_suspend, .serial_halt);

// >>> tb/utgsc_shifter_model.sv
// transmit shifter model: busy for one frame after each load
// assumes one load per frame; slow picks a long frame, halt freezes shifting
`timescale 1ns/1ns
module utgsc_shifter_model (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic tx_load,
  input  wire logic slow,
  input  wire logic serial_halt,
  output logic      tx_shift_busy
);
  logic [5:0] cnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cnt_q <= 6'h00;
    else if (tx_load) cnt_q <= slow ? 6'h28 : 6'h0c;
    else if (cnt_q != 6'h00 && !serial_halt) cnt_q <= cnt_q - 6'h01;
  end
  assign tx_shift_busy = cnt_q != 6'h00;
endmodule // utgsc_shifter_model

// >>> tb/tb_uart_tx_gap_and_suspend_ctrl.sv
// self-checking bench: registers, auto-baud flag, irq, frame gap, suspend modes
// assumes a zero wait state slave and random baud ticks from the bench
`timescale 1ns/1ns
module tb_uart_tx_gap_and_suspend_ctrl;
  logic clock, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_fifo_valid = 1'b0, fifo_mode = 1'b1;
  logic two_stop_bits = 1'b0, baud_tick = 1'b0, rx_busy = 1'b0, emu_suspend = 1'b0, slow = 1'b0;
  logic autobaud_detected = 1'b0, bprev = 1'b0, bt1 = 1'b0;
  logic hreadyout, hresp, tx_fifo_pop, tx_shift_busy, tx_load, autobaud_align_enable, serial_halt, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  tx_fifo_data = 8'h00, tx_load_data, gap;
  logic [7:0]  corner [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  int          bad_count = 0, cmp_count = 0, cyc = 0, tk = 0, got = 0;
  utgsc_top dut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .tx_fifo_valid, .tx_fifo_data, .tx_fifo_pop, .fifo_mode, .two_stop_bits,
    .baud_tick, .tx_shift_busy, .tx_load, .tx_load_data, .rx_busy, .emu_suspend, .autobaud_detected,
    .autobaud_align_enable, .serial_halt, .irq);
  utgsc_shifter_model u_shf (.clock, .nrst, .tx_load, .slow, .serial_halt, .tx_shift_busy);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({hreadyout, hresp}, 2'b10);
  endtask
  task automatic ab_pulse;
    autobaud_detected <= 1'b1;
    @(posedge clock);
    autobaud_detected <= 1'b0;
  endtask
  task automatic wait_load;
    do @(posedge clock); while (tx_load !== 1'b1);
    @(negedge clock);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  function automatic int exp_gap(input logic [7:0] g, input logic two);
    return (two && g != 8'h00) ? g - 1 : g;
  endfunction
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ticks seen after the shifter goes idle, latched at each load
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      wrap_up();
    end
    if (tx_load === 1'b1) got = tk;
    if (bprev === 1'b1 && tx_shift_busy === 1'b0) tk = 0;
    else if (baud_tick === 1'b1) tk++;
    bprev = tx_shift_busy;
    // ticks at least three cycles apart, so no tick lands between the last gap tick and the load
    baud_tick <= !baud_tick && !bt1 && (($urandom % 3) == 0);
    bt1 <= baud_tick;
  end
  initial begin
    void'($urandom(32'h106cb19f));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b0, utgsc_pkg::FFCT_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, utgsc_pkg::PRI_ADDR, 32'hffffffff);
    bus(1'b0, utgsc_pkg::PRI_ADDR, 32'h0);
    chk(rd, 32'h18);
    bus(1'b1, 32'h0001c190, 32'hffffffff);
    bus(1'b0, 32'h0001c190, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, utgsc_pkg::IRQ_MASK_ADDR, 32'h1);
    bus(1'b1, utgsc_pkg::FFCT_ADDR, 32'h0000ffff);
    bus(1'b0, utgsc_pkg::FFCT_ADDR, 32'h0);
    chk(rd, 32'h000020ff);
    chk(autobaud_align_enable, 1'b1);
    ab_pulse();
    bus(1'b0, utgsc_pkg::FFCT_ADDR, 32'h0);
    chk(rd, 32'h0000a0ff);
    settle(1);
    chk(irq, 1'b1);
    bus(1'b1, utgsc_pkg::FFCT_ADDR, 32'h00006000);
    bus(1'b1, utgsc_pkg::IRQ_STAT_ADDR, 32'h1);
    bus(1'b0, utgsc_pkg::FFCT_ADDR, 32'h0);
    chk(rd, 32'h00002000);
    chk(irq, 1'b0);
    bus(1'b1, utgsc_pkg::FFCT_ADDR, 32'h0);
    ab_pulse();
    bus(1'b0, utgsc_pkg::FFCT_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(autobaud_align_enable, 1'b0);
    tx_fifo_valid <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      for (int i = 0; i < 8; i++) begin
        gap = (i < 4) ? corner[i] : 8'($urandom);
        bus(1'b1, utgsc_pkg::FFCT_ADDR, {24'h0, gap});
        two_stop_bits <= j[0];
        // third pass leaves fifo mode, where no gap is inserted
        fifo_mode <= (j < 2);
        slow <= 1'($urandom);
        tx_fifo_data <= 8'($urandom);
        wait_load();
        wait_load();
        chk(tx_load_data, tx_fifo_data);
        // a zero gap may still overlap one stray tick before the load
        if (j == 2 || exp_gap(gap, j[0]) == 0) chk(got <= 1, 1'b1);
        else chk(got, exp_gap(gap, j[0]));
      end
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, utgsc_pkg::PRI_ADDR, 32'(m << 3));
      rx_busy <= 1'b1;
      emu_suspend <= 1'b1;
      settle(3);
      chk(serial_halt, m == 0);
      @(posedge clock);
      rx_busy <= 1'b0;
      settle(60);
      chk(serial_halt, m % 2 == 0);
      @(posedge clock);
      emu_suspend <= 1'b0;
      settle(3);
      chk(serial_halt, 1'b0);
    end
    wrap_up();
  end
endmodule // tb_uart_tx_gap_and_suspend_ctrl
